// *** pkg/port_ingress_defs.svh ***
// Register offsets, field positions, masks and reset values of the per-port ingress register bank
// What this block does
// - Force-ring-miss set: single entry ring filtering, a matching ring packet counts as miss.
// - Force-ring-miss clear: multi-entry ring filtering, a ring rule-set match counts as hit.
// - Receive-sniff bit 6 set, with global mirroring on, marks every received packet monitored, copied to sniffer.
// - Transmit-sniff bit 5 set, with global mirroring on, marks every transmitted packet monitored, copied to sniffer.
// - Sniffer-port bit 1 set makes the port transmit monitored packets.
// - Bit 7 set picks the highest priority among enabled classification sources.
// - Bit 6 set with bit 7 clear forms the priority as the OR of all available priorities.
// - MAC-address priority classification applies only while bit 4 is set.
// - VLAN priority classification applies only while bit 3 is set.
// - 802.1p tag priority classification applies only while bit 2 is set.
// - Diffserv priority classification applies only while bit 1 is set.
// - Access-list priority classification applies only while bit 0 is set.
`ifndef PORT_INGRESS_DEFS_SVH
`define PORT_INGRESS_DEFS_SVH

// Register indices inside one port's space; the byte address is four times the index
`define OFS_ACL_RING_CTL 12'h613
`define OFS_MIRROR_CTL 12'h800
`define OFS_PRIO_CTL 12'h801
`define OFS_CLASS_STATUS 12'h8F0
`define OFS_MON_COUNT 12'h8F1

// Writable bits of each configuration register; all others read as zero
`define MASK_ACL_RING_CTL 8'hFF
`define MASK_MIRROR_CTL 8'h62
`define MASK_PRIO_CTL 8'hDF
`define RESET_BYTE 8'h00

// Field positions
`define BIT_FORCE_RING_MISS 0
`define BIT_RX_SNIFF 6
`define BIT_TX_SNIFF 5
`define BIT_SNIFFER_PORT 1
`define BIT_PRIO_HIGHEST 7
`define BIT_PRIO_OR 6
`define BIT_PRIO_MAC 4
`define BIT_PRIO_VLAN 3
`define BIT_PRIO_TAG 2
`define BIT_PRIO_DSCP 1
`define BIT_PRIO_ACL 0

// Status byte layout
`define BIT_ST_RING_HIT 7
`define BIT_ST_RING_MISS 6
`define BIT_ST_MONITORED 5
`define BIT_ST_FOUND 3

`define NUM_PORTS_DEFAULT 7
`define NUM_SOURCES 5

`endif

// *** pkg/port_ingress_pkg.sv ***
// Types shared by the per-port ingress register bank
package port_ingress_pkg;
  typedef logic [2:0] prio_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ACL_RING,
    SEL_MIRROR,
    SEL_PRIO,
    SEL_STATUS,
    SEL_COUNT
  } reg_sel_e;
endpackage

// *** pkg/prio_resolve_if.sv ***
// Interface between the register bank and its priority resolver
`timescale 1ns/1ps
interface prio_resolve_if;
  import port_ingress_pkg::*;
  logic [4:0] src_valid;
  logic [4:0][2:0] src_prio;
  logic [7:0] ctl;
  prio_t result_prio;
  logic result_found;
  modport requester (
    output src_valid,
    output src_prio,
    output ctl,
    input result_prio,
    input result_found
  );
  modport resolver (
    input src_valid,
    input src_prio,
    input ctl,
    output result_prio,
    output result_found
  );
endinterface

// *** rtl/port_ingress_mirror_priority_regs.sv ***
// Per-port ring filter, mirroring and priority control registers with packet decisions
`timescale 1ns/1ps
`include "port_ingress_defs.svh"
module port_ingress_mirror_priority_regs
  import port_ingress_pkg::*;
#(
  parameter int NUM_PORTS = `NUM_PORTS_DEFAULT,
  parameter int ADR_W = 18
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mirror_global_en_i,
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_port_i,
  input wire logic rx_ring_i,
  input wire logic rx_ring_single_match_i,
  input wire logic rx_ring_set_match_i,
  input wire logic [4:0] src_valid_i,
  input wire logic [14:0] src_prio_i,
  input wire logic tx_valid_i,
  input wire logic [2:0] tx_port_i,
  output logic cls_valid_o,
  output logic [2:0] cls_port_o,
  output logic [2:0] cls_prio_o,
  output logic cls_found_o,
  output logic rx_monitor_o,
  output logic ring_single_o,
  output logic ring_hit_o,
  output logic ring_miss_o,
  output logic tx_monitor_o,
  output logic [2:0] tx_monitor_port_o,
  output logic [6:0] sniffer_map_o
);
  byte_t acl_ring_ctl [NUM_PORTS];
  byte_t mirror_ctl [NUM_PORTS];
  byte_t prio_ctl [NUM_PORTS];
  byte_t class_status [NUM_PORTS];
  byte_t mon_count [NUM_PORTS];

  function automatic logic port_ok(input logic [3:0] p);
    return (p != 4'h0) && (p <= 4'(NUM_PORTS));
  endfunction

  function automatic logic [2:0] port_slot(input logic [3:0] p);
    return 3'(p - 4'h1);
  endfunction

  // Bus decode: index = byte address / 4, port number in the top nibble of the index
  wire [15:0] bus_index = wb_adr_i[17:2];
  wire [3:0] bus_port = bus_index[15:12];
  wire [11:0] bus_ofs = bus_index[11:0];
  wire bus_port_ok = port_ok(bus_port);
  wire [2:0] bus_slot = port_slot(bus_port);
  wire bus_req = wb_cyc_i & wb_stb_i;
  reg_sel_e bus_sel;
  assign bus_sel = !bus_port_ok ? SEL_NONE :
                   (bus_ofs == `OFS_ACL_RING_CTL) ? SEL_ACL_RING :
                   (bus_ofs == `OFS_MIRROR_CTL) ? SEL_MIRROR :
                   (bus_ofs == `OFS_PRIO_CTL) ? SEL_PRIO :
                   (bus_ofs == `OFS_CLASS_STATUS) ? SEL_STATUS :
                   (bus_ofs == `OFS_MON_COUNT) ? SEL_COUNT : SEL_NONE;

  // A write lands only at the edge where the master sees ack, and only on byte lane 0
  wire wr_fire = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire wr_acl = wr_fire & (bus_sel == SEL_ACL_RING);
  wire wr_mirror = wr_fire & (bus_sel == SEL_MIRROR);
  wire wr_prio = wr_fire & (bus_sel == SEL_PRIO);
  wire wr_count = wr_fire & (bus_sel == SEL_COUNT);
  wire [7:0] wr_byte = wb_dat_i[7:0];

  byte_t rd_byte;
  assign rd_byte = (bus_sel == SEL_ACL_RING) ? acl_ring_ctl[bus_slot] :
                   (bus_sel == SEL_MIRROR) ? mirror_ctl[bus_slot] :
                   (bus_sel == SEL_PRIO) ? prio_ctl[bus_slot] :
                   (bus_sel == SEL_STATUS) ? class_status[bus_slot] :
                   (bus_sel == SEL_COUNT) ? mon_count[bus_slot] : `RESET_BYTE;

  // Unmapped addresses are acked with zero data so software never hangs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Receive path: per-packet lookup of the arriving port's settings
  wire rx_ok = rx_valid_i & port_ok({1'b0, rx_port_i});
  wire [2:0] rx_slot = port_slot({1'b0, rx_port_i});
  wire tx_ok = tx_valid_i & port_ok({1'b0, tx_port_i});
  wire [2:0] tx_slot = port_slot({1'b0, tx_port_i});
  byte_t rx_mirror;
  byte_t tx_mirror;
  byte_t rx_acl;
  assign rx_mirror = mirror_ctl[rx_slot];
  assign tx_mirror = mirror_ctl[tx_slot];
  assign rx_acl = acl_ring_ctl[rx_slot];

  // Per-port mirroring acts only while the global mirroring control is on
  wire next_rx_monitor = rx_ok & mirror_global_en_i & rx_mirror[`BIT_RX_SNIFF];
  wire next_tx_monitor = tx_ok & mirror_global_en_i & tx_mirror[`BIT_TX_SNIFF];

  // Ring packets: forced miss uses one entry; otherwise the ring rule set decides
  wire rx_force_miss = rx_acl[`BIT_FORCE_RING_MISS];
  wire rx_ring_pkt = rx_ok & rx_ring_i;
  wire next_ring_single = rx_ring_pkt & rx_force_miss;
  wire next_ring_hit = rx_ring_pkt & ~rx_force_miss & rx_ring_set_match_i;
  wire next_ring_miss = rx_ring_pkt &
                        (rx_force_miss ? 1'b1 : ~rx_ring_set_match_i);
  // A single-entry match is still reported as a miss, never as a hit
  wire ring_single_seen = next_ring_single & rx_ring_single_match_i;

  prio_resolve_if pr_bus ();
  assign pr_bus.src_valid = src_valid_i;
  assign pr_bus.src_prio = src_prio_i;
  assign pr_bus.ctl = prio_ctl[rx_slot];

  prio_resolver u_prio_resolver (
    .pr(pr_bus.resolver)
  );

  logic [6:0] next_sniffer_map;
  always_comb begin
    next_sniffer_map = 7'h00;
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_sniffer_map[i] = mirror_ctl[i][`BIT_SNIFFER_PORT];
    end
  end

  // Decision outputs, one cycle after the packet strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cls_valid_o <= 1'b0;
      cls_port_o <= 3'h0;
      cls_prio_o <= 3'h0;
      cls_found_o <= 1'b0;
      rx_monitor_o <= 1'b0;
      ring_single_o <= 1'b0;
      ring_hit_o <= 1'b0;
      ring_miss_o <= 1'b0;
    end else begin
      cls_valid_o <= rx_ok;
      if (rx_ok) begin
        cls_port_o <= rx_port_i;
        cls_prio_o <= pr_bus.result_prio;
        cls_found_o <= pr_bus.result_found;
      end
      rx_monitor_o <= next_rx_monitor;
      ring_single_o <= next_ring_single;
      ring_hit_o <= next_ring_hit;
      ring_miss_o <= next_ring_miss;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_monitor_o <= 1'b0;
      tx_monitor_port_o <= 3'h0;
      sniffer_map_o <= 7'h00;
    end else begin
      tx_monitor_o <= next_tx_monitor;
      if (tx_ok) begin
        tx_monitor_port_o <= tx_port_i;
      end
      // Sniffer ports stay designated even with global mirroring off; only copies stop
      sniffer_map_o <= next_sniffer_map;
    end
  end

  // Status byte of the last received packet on each port
  byte_t next_status;
  always_comb begin
    next_status = 8'h00;
    next_status[`BIT_ST_RING_HIT] = next_ring_hit;
    next_status[`BIT_ST_RING_MISS] = next_ring_miss | ring_single_seen;
    next_status[`BIT_ST_MONITORED] = next_rx_monitor;
    next_status[`BIT_ST_FOUND] = pr_bus.result_found;
    next_status[2:0] = pr_bus.result_prio;
  end

  // Configuration registers; masks keep reserved read-only bits at zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        acl_ring_ctl[i] <= `RESET_BYTE;
        mirror_ctl[i] <= `RESET_BYTE;
        prio_ctl[i] <= `RESET_BYTE;
      end
    end else begin
      if (wr_acl) begin
        acl_ring_ctl[bus_slot] <= wr_byte & `MASK_ACL_RING_CTL;
      end
      if (wr_mirror) begin
        mirror_ctl[bus_slot] <= wr_byte & `MASK_MIRROR_CTL;
      end
      // Several enables at once are accepted; the outcome then follows the mode bits
      if (wr_prio) begin
        prio_ctl[bus_slot] <= wr_byte & `MASK_PRIO_CTL;
      end
    end
  end

  // Monitor counters: a write clears, but a same-cycle event still counts
  logic [1:0] mon_inc [NUM_PORTS];
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      mon_inc[i] = 2'h0;
      if (next_rx_monitor && rx_slot == 3'(i)) begin
        mon_inc[i] = mon_inc[i] + 2'h1;
      end
      if (next_tx_monitor && tx_slot == 3'(i)) begin
        mon_inc[i] = mon_inc[i] + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        class_status[i] <= `RESET_BYTE;
        mon_count[i] <= `RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (rx_ok && rx_slot == 3'(i)) begin
          class_status[i] <= next_status;
        end
        if (wr_count && bus_slot == 3'(i)) begin
          mon_count[i] <= {6'h00, mon_inc[i]};
        end else begin
          mon_count[i] <= mon_count[i] + {6'h00, mon_inc[i]};
        end
      end
    end
  end
endmodule

// *** rtl/prio_resolver.sv ***
// Combinational ingress priority resolver
`timescale 1ns/1ps
`include "port_ingress_defs.svh"
module prio_resolver
  import port_ingress_pkg::*;
(
  prio_resolve_if.resolver pr
);
  logic [4:0] enabled;
  logic [4:0] active;
  prio_t max_prio;
  prio_t or_prio;
  prio_t first_prio;
  logic any_active;

  // Each source counts only while its own enable bit is set
  assign enabled[`BIT_PRIO_MAC] = pr.ctl[`BIT_PRIO_MAC];
  assign enabled[`BIT_PRIO_VLAN] = pr.ctl[`BIT_PRIO_VLAN];
  assign enabled[`BIT_PRIO_TAG] = pr.ctl[`BIT_PRIO_TAG];
  assign enabled[`BIT_PRIO_DSCP] = pr.ctl[`BIT_PRIO_DSCP];
  assign enabled[`BIT_PRIO_ACL] = pr.ctl[`BIT_PRIO_ACL];
  assign active = enabled & pr.src_valid;
  assign any_active = |active;

  always_comb begin
    max_prio = 3'h0;
    or_prio = 3'h0;
    first_prio = 3'h0;
    for (int k = 0; k < `NUM_SOURCES; k++) begin
      if (active[k] && pr.src_prio[k] > max_prio) begin
        max_prio = pr.src_prio[k];
      end
      if (active[k]) begin
        or_prio = or_prio | pr.src_prio[k];
        first_prio = pr.src_prio[k];
      end
    end
  end

  // Highest wins over OR when both are set; with neither, the highest-numbered enabled source with a valid priority is used
  assign pr.result_prio = pr.ctl[`BIT_PRIO_HIGHEST] ? max_prio :
                          pr.ctl[`BIT_PRIO_OR] ? or_prio :
                          first_prio;
  assign pr.result_found = any_active;
endmodule

// *** test/port_ingress_mirror_priority_regs_properties.sv ***
// Port-level properties of the per-port ingress register bank
`timescale 1ns/1ps
module port_ingress_mirror_priority_regs_properties (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic mirror_global_en_i,
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_port_i,
  input wire logic rx_ring_i,
  input wire logic tx_valid_i,
  input wire logic [2:0] tx_port_i,
  input wire logic cls_valid_o,
  input wire logic rx_monitor_o,
  input wire logic ring_single_o,
  input wire logic ring_hit_o,
  input wire logic ring_miss_o,
  input wire logic tx_monitor_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rx;
    rx_valid_i && rx_port_i != 3'h0;
  endsequence
  property p_ack_next; s_take |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  property p_cls; s_rx |=> cls_valid_o; endproperty
  property p_cls_cause; cls_valid_o |-> $past(rx_valid_i && rx_port_i != 3'h0); endproperty
  property p_excl; !(ring_hit_o && ring_miss_o); endproperty
  property p_single; ring_single_o |-> ring_miss_o && !ring_hit_o; endproperty
  property p_ring_cause; ring_hit_o || ring_miss_o |-> $past(rx_valid_i && rx_ring_i); endproperty
  property p_rx_mon; rx_monitor_o |-> $past(mirror_global_en_i && rx_valid_i); endproperty
  property p_tx_mon; tx_monitor_o |-> $past(mirror_global_en_i && tx_valid_i); endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_dat_hi: assert property (p_dat_hi)
    else $error("upper read bits not zero");
  a_cls: assert property (p_cls)
    else $error("classification result missing");
  a_cls_cause: assert property (p_cls_cause)
    else $error("classification without packet");
  a_excl: assert property (p_excl)
    else $error("hit and miss together");
  a_single: assert property (p_single)
    else $error("forced ring packet not a miss");
  a_ring_cause: assert property (p_ring_cause)
    else $error("ring result without ring packet");
  a_rx_mon: assert property (p_rx_mon)
    else $error("rx monitor without cause");
  a_tx_mon: assert property (p_tx_mon)
    else $error("tx monitor without cause");
endmodule
bind port_ingress_mirror_priority_regs port_ingress_mirror_priority_regs_properties i_props (.*);

// *** test/port_ingress_mirror_priority_regs_tb_top.sv ***
// Self-checking bench for the per-port ingress register bank
`timescale 1ns/1ps
`include "port_ingress_defs.svh"
module port_ingress_mirror_priority_regs_tb_top;
  import port_ingress_pkg::*;
  logic core_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic mirror_global_en_i, rx_valid_i, rx_ring_i, tx_valid_i;
  logic rx_ring_single_match_i, rx_ring_set_match_i;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, d;
  logic [2:0] rx_port_i, tx_port_i, cls_port_o, cls_prio_o, tx_monitor_port_o;
  logic [4:0] src_valid_i;
  logic [14:0] src_prio_i;
  logic [6:0] sniffer_map_o, sm;
  logic cls_valid_o, cls_found_o, rx_monitor_o, ring_single_o, ring_hit_o, ring_miss_o;
  logic tx_monitor_o;
  int miscompares = 0;
  int checks = 0;
  logic [31:0] seed = 32'h867a_ec66;
  logic [7:0] rg [1:7][3];
  logic [7:0] cnt [1:7], st [1:7];
  localparam logic [11:0] OFS [3] = '{`OFS_ACL_RING_CTL, `OFS_MIRROR_CTL, `OFS_PRIO_CTL};
  // Writable bits follow the documented fields, except all eight bits of the ring control register; everything else reads zero
  localparam logic [7:0] MSK [3] = '{8'hff, 8'h62, 8'hdf};
  port_ingress_mirror_priority_regs i_dut (.*);
  initial begin
    core_clk_i = 0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] pt, input logic [11:0] of,
                    input logic [31:0] dt, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {pt, of, 2'b00};
    wb_dat_i <= dt;
    wb_sel_i <= s;
    do @(posedge core_clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n >= 20) miscompares++;
    r = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  function automatic logic [3:0] prio(input logic [7:0] c, input logic [4:0] v,
                                      input logic [14:0] p);
    logic [4:0] a;
    logic [2:0] r;
    a = c[4:0] & v;
    r = 0;
    for (int k = 0; k < 5; k++) begin
      if (!a[k]) continue;
      if (c[7]) r = (p[3*k+:3] > r) ? p[3*k+:3] : r;
      else if (c[6]) r |= p[3*k+:3];
      else r = p[3*k+:3];
    end
    return {|a, r};
  endfunction
  task automatic cfg(input logic [2:0] b);
    for (int p = 1; p < 8; p++) begin
      for (int r = 0; r < 3; r++) begin
        d = rnd();
        // Modes are forced per block so every combination is reached
        if (r == 2) d[7:6] = b[1:0];
        // One block keeps software's one-bit-at-a-time advice for the priority register
        if (r == 2 && b == 3'h0) d[7:0] = 8'h01 << d[10:8];
        if (r == 0) d[0] = b[2];
        wb(1, 4'(p), OFS[r], d, 4'h1, q);
        rg[p][r] = d[7:0] & MSK[r];
      end
    end
  endtask
  task automatic pkts(input int n);
    logic ev, er, fm, erm, etm, esm;
    logic [2:0] erg;
    logic [3:0] ep;
    logic [2:0] pp, tp;
    logic [31:0] r;
    for (int i = 0; i <= n; i++) begin
      @(posedge core_clk_i);
      ev = rx_valid_i && rx_port_i != 0;
      pp = rx_port_i;
      ep = ev ? prio(rg[pp][2], src_valid_i, src_prio_i) : 4'h0;
      er = ev && rx_ring_i;
      fm = ev ? rg[pp][0][0] : 1'b0;
      erm = ev && mirror_global_en_i && rg[pp][1][6];
      tp = tx_port_i;
      etm = tx_valid_i && tp != 0 && mirror_global_en_i && rg[tp][1][5];
      esm = rx_ring_set_match_i;
      erg = {er && fm, er && !fm && esm, er && (fm || !esm)};
      if (ev) st[pp] = {erg[1], erg[0], erm, 1'b0, ep};
      if (erm) cnt[pp]++;
      if (etm) cnt[tp]++;
      r = rnd();
      rx_valid_i <= r[0] && i < n;
      rx_port_i <= r[3:1];
      rx_ring_i <= r[4];
      rx_ring_single_match_i <= r[5];
      rx_ring_set_match_i <= r[6];
      mirror_global_en_i <= r[7] | r[18];
      tx_valid_i <= r[8] && i < n;
      tx_port_i <= r[11:9];
      src_valid_i <= r[16:12];
      src_prio_i <= 15'(rnd());
      #1;
      chk(cls_valid_o, ev);
      if (ev) chk({cls_found_o, cls_prio_o}, ep);
      if (ev) chk(cls_port_o, pp);
      chk({ring_single_o, ring_hit_o, ring_miss_o}, erg);
      chk(rx_monitor_o, erm);
      chk(tx_monitor_o, etm);
      if (etm) chk(tx_monitor_port_o, tp);
    end
  endtask
  initial begin
    {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {mirror_global_en_i, rx_valid_i, rx_port_i, rx_ring_i, rx_ring_single_match_i} = '0;
    {rx_ring_set_match_i, src_valid_i, src_prio_i, tx_valid_i, tx_port_i} = '0;
    cnt = '{default: 8'h00};
    st = '{default: 8'h00};
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1;
    for (int p = 1; p < 8; p++) begin
      for (int r = 0; r < 3; r++) begin
        wb(0, 4'(p), OFS[r], 0, 4'hf, q);
        chk(q, 0);
        d = rnd();
        wb(1, 4'(p), OFS[r], d, 4'hf, q);
        rg[p][r] = d[7:0] & MSK[r];
        wb(1, 4'(p), OFS[r], rnd(), 4'he, q);
        wb(0, 4'(p), OFS[r], 0, 4'hf, q);
        chk(q, {24'h00_0000, rg[p][r]});
      end
      sm[p-1] = rg[p][1][1];
    end
    chk(sniffer_map_o, sm);
    wb(1, 4'h0, OFS[1], 32'hffff_ffff, 4'hf, q);
    wb(0, 4'h0, OFS[1], 0, 4'hf, q);
    chk(q, 0);
    wb(0, 4'h1, 12'h7ff, 0, 4'hf, q);
    chk(q, 0);
    for (int b = 0; b < 8; b++) begin
      cfg(3'(b));
      pkts(40);
      // Status is read-only and must survive a write; the counter clears on any write that enables byte lane 0
      for (int p = 1; p < 8; p++) begin
        wb(1, 4'(p), `OFS_CLASS_STATUS, 32'hffff_ffff, 4'hf, q);
        wb(0, 4'(p), `OFS_CLASS_STATUS, 0, 4'hf, q);
        chk(q, {24'h00_0000, st[p]});
        wb(0, 4'(p), `OFS_MON_COUNT, 0, 4'hf, q);
        chk(q, {24'h00_0000, cnt[p]});
        wb(1, 4'(p), `OFS_MON_COUNT, 0, 4'h1, q);
        cnt[p] = 8'h00;
      end
    end
    wrap_up();
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
